// ===== fsps_pkg.sv
// Constants shared by the flash self-program sequencer.
// Assumes a 20 MHz system clock and a 16-bit program pointer.
package fsps_pkg;
  // Wishbone register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Control register bit positions.
  localparam int EN_BIT      = 0;
  localparam int ERASE_BIT   = 1;
  localparam int WRITE_BIT   = 2;
  localparam int LOCKRD_BIT  = 3;
  localparam int REENABLE_BIT = 4;
  localparam int CMD_BITS    = 5;

  // Legal command codes in the low five control bits.
  localparam logic [4:0] CMD_LOAD     = 5'h01;
  localparam logic [4:0] CMD_ERASE    = 5'h03;
  localparam logic [4:0] CMD_WRITE    = 5'h05;
  localparam logic [4:0] CMD_LOCKRD   = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_NONE     = 5'h00;

  // Status register bit positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EE_BIT   = 1;
  localparam int ST_WIN_BIT  = 2;

  // Pointer layout: byte bit, word-in-page field, page index field.
  localparam int PTR_BITS   = 16;
  localparam int WORD_BITS  = 5;
  localparam int PAGE_WORDS = 32;
  localparam int WORD_LSB   = 1;
  localparam int PAGE_LSB   = WORD_LSB + WORD_BITS;
  localparam int PAGE_BITS  = PTR_BITS - PAGE_LSB;

  // Pointer values that select fuse and lock bytes.
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK     = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  // Erased flash and empty buffer words read as all ones.
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0]  UNMAPPED_BYTE = 8'hFF;

  // Command windows in clock cycles.
  localparam int WIN_BITS     = 3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam logic [2:0] WIN_LAST     = 3'h1;

  // Programming time from the calibrated oscillator, in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_MIN_NS   = 3700000;
  localparam int PROG_MAX_NS   = 4500000;
  localparam int PROG_CYCLES   = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_BITS     = 17;

  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_ERASE,
    FSPS_STREAM,
    FSPS_PROG
  } fsps_state_t;
endpackage

// ===== fsps_countdown.sv
// Loadable down-counter used for the command window and the program timer.
// Assumes start_i and hold_i come from logic on the same clock.
module fsps_countdown #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         hold_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_val_i,
  output logic      [W-1:0] cnt_o,
  output logic              run_o
);
  logic [W-1:0] next_cnt;

  // Restart wins over counting; the count stops at zero.
  assign next_cnt = start_i ? load_val_i : (run_o ? cnt_o - W'(1) : cnt_o);
  assign run_o    = (cnt_o != '0);

  // A reset is ignored while hold_i protects a running operation.
  always_ff @(posedge clk_i) begin
    if (rst_i && !hold_i) begin
      cnt_o <= '0;
    end else begin
      cnt_o <= next_cnt;
    end
  end
endmodule

// ===== fsps_sequencer.sv
// Flash self-program sequencer with its Wishbone control registers.
// Assumes the CPU core pulses store_i and load_i on this clock and obeys cpu_halt_o.
// Summary of operation
// - Code 00000011 then store erases page.
// - Erase uses page field only, ignores data.
// - CPU halted for whole page erase.
// - Code 00000001 then store loads one word.
// - Word-in-page field selects buffer location.
// - Buffer cleared after write, reenable, reset.
// - EEPROM write discards partly loaded buffer.
// - Code 00000101 then store writes page.
// - CPU halted until page is programmed.
// - Loads accepted any order, before/after erase.
// - Low pointer bits word, high bits page.
// - Load returns byte selected by whole pointer.
// - EEPROM busy blocks programming and fuse reads.
// - Lock read: pointer 0x0001, load within three.
// - Lock mode clears on read or timeout.
// - Fuse low, extended, high by pointer.
// - Programmed bits read zero, unprogrammed one.
// - Reset lets running flash operation complete.
// - Operations timed between 3.7 and 4.5 ms.
// - Enable arms store for four cycles.
// - Enable stays set during erase or write.
// - Illegal command codes start nothing.
module fsps_sequencer #(
  parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // CPU core instruction side.
  input  wire logic        store_i,
  input  wire logic        load_i,
  input  wire logic [15:0] ptr_i,
  input  wire logic [15:0] word_data_i,
  output logic             cpu_halt_o,
  output logic             load_take_o,
  output logic      [7:0]  load_data_o,
  // Neighbour status and non-volatile bytes; a one marks a programmed bit.
  input  wire logic        eeprom_busy_i,
  input  wire logic [7:0]  fuse_low_prog_i,
  input  wire logic [7:0]  fuse_high_prog_i,
  input  wire logic [7:0]  fuse_ext_prog_i,
  input  wire logic [7:0]  lock_prog_i,
  // Flash array strobes.
  output logic             flash_erase_o,
  output logic             flash_we_o,
  output logic      [9:0]  flash_page_o,
  output logic      [4:0]  flash_word_o,
  output logic      [15:0] flash_wdata_o
);
  fsps_pkg::fsps_state_t state;
  fsps_pkg::fsps_state_t next_state;
  logic [4:0]  ctrl;
  logic [15:0] buf_mem [fsps_pkg::PAGE_WORDS];
  logic [fsps_pkg::PAGE_WORDS-1:0] buf_valid;
  logic [4:0]  stream_idx;
  logic [2:0]  win_cnt;
  logic        win_run;
  logic [16:0] prog_cnt;
  logic        prog_run;

  // Bus decode; the slave answers every access one cycle after the request.
  wire         wb_go     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire         wb_wr     = wb_go && wb_we_i;
  wire         hit_ctrl  = (wb_adr_i == fsps_pkg::CTRL_OFS);
  wire         hit_stat  = (wb_adr_i == fsps_pkg::STAT_OFS);
  wire         busy      = (state != fsps_pkg::FSPS_IDLE);
  wire [4:0]   wr_code   = wb_dat_i[fsps_pkg::CMD_BITS-1:0];
  wire         code_ok   = (wr_code == fsps_pkg::CMD_LOAD) || (wr_code == fsps_pkg::CMD_ERASE)
                        || (wr_code == fsps_pkg::CMD_WRITE) || (wr_code == fsps_pkg::CMD_LOCKRD)
                        || (wr_code == fsps_pkg::CMD_REENABLE);
  wire         ctrl_wr   = wb_wr && hit_ctrl && wb_sel_i[0] && !busy
                        && !eeprom_busy_i;
  wire         cmd_start = ctrl_wr && code_ok;

  // Pointer split into word and page fields.
  wire [4:0]   ptr_word  = ptr_i[fsps_pkg::WORD_LSB +: fsps_pkg::WORD_BITS];
  wire [9:0]   ptr_page  = ptr_i[fsps_pkg::PAGE_LSB +: fsps_pkg::PAGE_BITS];

  // A store or load is taken as the armed command only inside the window.
  wire         store_go  = store_i && win_run && !busy && !eeprom_busy_i
                        && (ctrl != fsps_pkg::CMD_NONE);
  wire         go_load   = store_go && (ctrl == fsps_pkg::CMD_LOAD);
  wire         go_erase  = store_go && (ctrl == fsps_pkg::CMD_ERASE);
  wire         go_write  = store_go && (ctrl == fsps_pkg::CMD_WRITE);
  wire         load_go   = load_i && !eeprom_busy_i && (ctrl == fsps_pkg::CMD_LOCKRD)
                        && (win_cnt > (fsps_pkg::STORE_WINDOW - fsps_pkg::LOAD_WINDOW));
  wire         win_end   = (win_cnt == fsps_pkg::WIN_LAST) && !cmd_start;
  wire         prog_done = (state == fsps_pkg::FSPS_PROG) && (prog_cnt == 17'h00001);
  wire         write_done = prog_done && ctrl[fsps_pkg::WRITE_BIT];
  wire         last_word = (stream_idx == 5'(fsps_pkg::PAGE_WORDS - 1));

  // Buffer clear sources; the EEPROM discard only matters once loading began.
  wire         buf_clear = write_done
                        || (cmd_start && (wr_code == fsps_pkg::CMD_REENABLE))
                        || (eeprom_busy_i && (buf_valid != '0))
                        || (rst_i && (state != fsps_pkg::FSPS_STREAM));

  // Byte selected by the pointer in lock and fuse read mode, inverted.
  wire [7:0]   rd_prog   = (ptr_i == fsps_pkg::PTR_FUSE_LOW)  ? fuse_low_prog_i  :
                           (ptr_i == fsps_pkg::PTR_LOCK)      ? lock_prog_i      :
                           (ptr_i == fsps_pkg::PTR_FUSE_EXT)  ? fuse_ext_prog_i  :
                           (ptr_i == fsps_pkg::PTR_FUSE_HIGH) ? fuse_high_prog_i :
                           ~fsps_pkg::UNMAPPED_BYTE;
  wire [7:0]   rd_byte   = ~rd_prog;

  // Read data for the two registers; any other address reads zero.
  wire [31:0]  stat_word = {29'h0, win_run, eeprom_busy_i, busy};
  wire [31:0]  rd_word   = hit_ctrl ? {27'h0, ctrl} : (hit_stat ? stat_word : 32'h0);

  // Command window: four cycles after each accepted control write.
  fsps_countdown #(
    .W (fsps_pkg::WIN_BITS)
  ) u_window (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .hold_i     (1'b0),
    .start_i    (cmd_start),
    .load_val_i (fsps_pkg::STORE_WINDOW),
    .cnt_o      (win_cnt),
    .run_o      (win_run)
  );

  // Programming timer; a reset cannot cut a running erase or write short.
  fsps_countdown #(
    .W (fsps_pkg::PROG_BITS)
  ) u_prog_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .hold_i     (busy),
    .start_i    (go_erase || (state == fsps_pkg::FSPS_STREAM && last_word)),
    .load_val_i (17'(PROG_CYCLES)),
    .cnt_o      (prog_cnt),
    .run_o      (prog_run)
  );

  // Operation sequence: erase waits the program time; write streams then waits.
  always_comb begin
    next_state = state;
    unique case (state)
      fsps_pkg::FSPS_IDLE: begin
        if (go_erase) begin
          next_state = fsps_pkg::FSPS_ERASE;
        end else if (go_write) begin
          next_state = fsps_pkg::FSPS_STREAM;
        end
      end
      fsps_pkg::FSPS_ERASE: begin
        if (prog_cnt == 17'h00001) begin
          next_state = fsps_pkg::FSPS_IDLE;
        end
      end
      fsps_pkg::FSPS_STREAM: begin
        if (last_word) begin
          next_state = fsps_pkg::FSPS_PROG;
        end
      end
      fsps_pkg::FSPS_PROG: begin
        if (prog_done) begin
          next_state = fsps_pkg::FSPS_IDLE;
        end
      end
    endcase
  end

  // State survives a reset while an operation is in flight.
  // An unknown busy at power-up falls to the reset branch, so the state cannot lock up unknown.
  always_ff @(posedge clk_i) begin
    if (!rst_i || busy) begin
      state <= next_state;
    end else begin
      state <= fsps_pkg::FSPS_IDLE;
    end
  end

  // The CPU stays halted for the whole erase or write.
  assign cpu_halt_o = busy;

  // Control bits: set by a legal write, held during an operation, cleared on use, window end or idle reset.
  always_ff @(posedge clk_i) begin
    if (rst_i && !busy) begin
      ctrl <= fsps_pkg::CMD_NONE;
    end else if (cmd_start) begin
      ctrl <= wr_code;
    end else if ((store_go && !go_erase && !go_write) || load_go) begin
      ctrl <= fsps_pkg::CMD_NONE;
    end else if (busy) begin
      ctrl <= (prog_done || (state == fsps_pkg::FSPS_ERASE && prog_cnt == 17'h00001))
              ? fsps_pkg::CMD_NONE : ctrl;
    end else if (win_end && !store_go) begin
      ctrl <= fsps_pkg::CMD_NONE;
    end
  end

  // Page buffer words; loads go to the word field in any order.
  always_ff @(posedge clk_i) begin
    if (go_load) begin
      buf_mem[ptr_word] <= word_data_i;
    end
  end

  // Valid marks; unloaded words program as erased.
  always_ff @(posedge clk_i) begin
    if (buf_clear) begin
      buf_valid <= '0;
    end else if (go_load) begin
      buf_valid[ptr_word] <= 1'b1;
    end
  end

  // Page write streams the buffer into flash one word per cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i && !busy) begin
      stream_idx <= 5'h00;
    end else if (state == fsps_pkg::FSPS_STREAM) begin
      stream_idx <= stream_idx + 5'h01;
    end else begin
      stream_idx <= 5'h00;
    end
  end

  // Flash strobes and addresses; the page comes only from the page field.
  always_ff @(posedge clk_i) begin
    flash_erase_o <= go_erase;
    flash_we_o    <= (state == fsps_pkg::FSPS_STREAM);
    flash_word_o  <= stream_idx;
    flash_wdata_o <= buf_valid[stream_idx] ? buf_mem[stream_idx] : fsps_pkg::ERASED_WORD;
    if (rst_i && !busy) begin
      flash_page_o <= 10'h000;
    end else if (go_erase || go_write) begin
      flash_page_o <= ptr_page;
    end
  end

  // Lock and fuse byte answer, one cycle after the load.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_take_o <= 1'b0;
      load_data_o <= 8'h00;
    end else begin
      load_take_o <= load_go;
      load_data_o <= load_go ? rd_byte : load_data_o;
    end
  end

  // Wishbone answer: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_go;
      wb_dat_o <= (wb_go && !wb_we_i) ? rd_word : 32'h0;
    end
  end

  // Helper copies for the checks below.
  logic [4:0] past_word;
  always_ff @(posedge clk_i) begin
    past_word <= ptr_word;
  end

  // Checks on the sequencer's own behaviour.
  erase_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go_erase |=> cpu_halt_o [*8])
    else $error("CPU not held during page erase.");
  write_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == fsps_pkg::FSPS_PROG && !prog_done) |-> cpu_halt_o ##1 cpu_halt_o)
    else $error("CPU released before page write finished.");
  window_close_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!busy && win_end && !store_go && !go_load && !load_go) |=> ctrl == fsps_pkg::CMD_NONE)
    else $error("Control bits survived the command window.");
  enable_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && !prog_done && prog_cnt != 17'h00001) |=> ctrl[fsps_pkg::EN_BIT])
    else $error("Enable bit dropped during an operation.");
  load_slot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (go_load && !buf_clear) |=> buf_valid[past_word])
    else $error("Loaded word not marked in its slot.");
  write_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    write_done |=> (buf_valid == '0) && !busy)
    else $error("Buffer not cleared after page write.");
  eeprom_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    eeprom_busy_i |-> !store_go && !load_go && !cmd_start)
    else $error("Flash access taken while EEPROM busy.");
  fuse_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_go && ptr_i == fsps_pkg::PTR_FUSE_LOW)
    |=> load_take_o && (load_data_o == ~$past(fuse_low_prog_i)))
    else $error("Fuse low byte returned wrong.");
  bad_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && !code_ok && ctrl == fsps_pkg::CMD_NONE) |=> ctrl == fsps_pkg::CMD_NONE)
    else $error("Illegal code started an operation.");
  prog_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go_erase |=> prog_cnt == 17'(PROG_CYCLES))
    else $error("Program timer not loaded with its time.");
  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone ack not a single cycle.");

  // Main scenarios.
  erase_seen_c: cover property (@(posedge clk_i) go_erase ##[1:20] busy);
  write_seen_c: cover property (@(posedge clk_i) go_write);
  load_seen_c:  cover property (@(posedge clk_i) go_load ##[1:8] go_load);
  fuse_seen_c:  cover property (@(posedge clk_i) load_go);
endmodule

// ===== fsps_cpu_model.sv
// CPU core model that issues store and load program instructions.
// Assumes the bench calls its tasks at rising edges of clk_i and places
// each request inside or after the command window that it is testing.
module fsps_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        take_i,
  input  wire logic [7:0]  data_i,
  output logic             store_o,
  output logic             load_o,
  output logic      [15:0] ptr_o,
  output logic      [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The core starts with no instruction in flight.
  initial begin
    store_o = 1'b0;
    load_o  = 1'b0;
    ptr_o   = 16'h0000;
    wdata_o = 16'h0000;
  end

  // One store pulse after d idle cycles; released lines show the inverse value.
  task automatic store(input logic [15:0] p, input logic [15:0] w, input int d);
    repeat (d) @(posedge clk_i);
    store_o <= 1'b1;
    ptr_o   <= p;
    wdata_o <= w;
    @(posedge clk_i);
    store_o <= 1'b0;
    ptr_o   <= ~p;
    wdata_o <= ~w;
  endtask

  // One load pulse after d idle cycles; the answer is taken one edge later.
  task automatic load(input logic [15:0] p, input int d, output logic tk, output logic [7:0] q);
    repeat (d) @(posedge clk_i);
    load_o <= 1'b1;
    ptr_o  <= p;
    @(posedge clk_i);
    load_o <= 1'b0;
    ptr_o  <= ~p;
    @(posedge clk_i);
    tk = take_i;
    q  = data_i;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes the sequencer package and the CPU core model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 40;

  logic        clk_i = 1'b0;
  logic        rst_i, wb_cyc, wb_stb, wb_we, wb_ack, ee_busy, halt, take;
  logic        store, load, fl_erase, fl_we;
  logic [7:0]  wb_adr, fuse_lo, fuse_hi, fuse_ext, lock_b, ldat;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  logic [15:0] ptr, wdata, fl_wdata;
  logic [9:0]  fl_page, er_page, we_page;
  logic [4:0]  fl_word;
  logic [15:0] cap [32];
  int          failures = 0;
  int          total_checks = 0;
  int          we_cnt = 0;
  int          er_cnt = 0;
  int          halt_cnt = 0;

  // Free-running 20 MHz system clock.
  always #25 clk_i = ~clk_i;

  fsps_sequencer #(.PROG_CYCLES(PROG)) fsps_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .store_i(store), .load_i(load),
    .ptr_i(ptr), .word_data_i(wdata), .cpu_halt_o(halt), .load_take_o(take),
    .load_data_o(ldat), .eeprom_busy_i(ee_busy), .fuse_low_prog_i(fuse_lo),
    .fuse_high_prog_i(fuse_hi), .fuse_ext_prog_i(fuse_ext), .lock_prog_i(lock_b),
    .flash_erase_o(fl_erase), .flash_we_o(fl_we), .flash_page_o(fl_page),
    .flash_word_o(fl_word), .flash_wdata_o(fl_wdata));

  fsps_cpu_model fsps_cpu_model_i (
    .clk_i(clk_i), .take_i(take), .data_i(ldat), .store_o(store),
    .load_o(load), .ptr_o(ptr), .wdata_o(wdata));

  // Records flash strobes and counts halted cycles.
  always @(posedge clk_i) begin
    if (fl_we) begin
      cap[fl_word] <= fl_wdata;
      we_page      <= fl_page;
      we_cnt       <= we_cnt + 1;
    end
    if (fl_erase) begin
      er_page <= fl_page;
      er_cnt  <= er_cnt + 1;
    end
    if (halt === 1'b1) halt_cnt <= halt_cnt + 1;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares one result with its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, fsps_pkg::CTRL_OFS, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Waits under a bound until the CPU is released.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (halt === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic ld(input int s, input logic [15:0] w, input int d);
    wr(32'h0000_0001);
    fsps_cpu_model_i.store({10'h2AF, s[4:0], 1'b1}, w, d);
  endtask

  task automatic pw();
    wr(32'h0000_0005);
    fsps_cpu_model_i.store(16'hABC0, 16'h0000, 0);
    wait_idle();
  endtask

  // Fuse and lock bytes through the load instruction, then refusals.
  task automatic t_lock();
    logic tk;
    logic [7:0] q;
    logic [7:0] exp [4];
    exp = '{~fuse_lo, ~lock_b, ~fuse_ext, ~fuse_hi};
    for (int i = 0; i < 4; i++) begin
      wr(32'h0000_0009);
      fsps_cpu_model_i.load(16'(i), i % 2, tk, q);
      chk(32'(tk), 32'h1);
      chk(32'(q), 32'(exp[i]));
      rd(fsps_pkg::CTRL_OFS, 32'h0);
    end
    wr(32'h0000_0009);
    fsps_cpu_model_i.load(16'h0001, 2, tk, q);
    chk(32'(tk), 32'h0);
    wr(32'h0000_0009);
    ee_busy <= 1'b1;
    fsps_cpu_model_i.load(16'h0001, 0, tk, q);
    chk(32'(tk), 32'h0);
    ee_busy <= 1'b0;
    $display("test lock done");
  endtask

  // Page erase, optionally with a reset in mid operation.
  task automatic t_erase(input bit mid_rst);
    int h, e;
    h = halt_cnt;
    e = er_cnt;
    wr(32'h0000_0003);
    fsps_cpu_model_i.store(16'hABCD, 16'h1234, 2);
    rd(fsps_pkg::CTRL_OFS, 32'h3);
    rd(fsps_pkg::STAT_OFS, 32'h1);
    if (mid_rst) begin
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
    end
    wait_idle();
    chk(32'(halt_cnt - h), 32'(PROG));
    chk(32'(er_cnt - e), 32'h1);
    chk(32'(er_page), 32'h2AF);
    rd(fsps_pkg::CTRL_OFS, 32'h0);
    $display("test erase done");
  endtask

  // Loads in falling order around an erase, then two page writes.
  task automatic t_page();
    int c, h;
    for (int s = 30; s >= 0; s -= 2) begin
      if (s == 14) t_erase(1'b0);
      ld(s, 16'hA500 + 16'(s), s % 3);
    end
    c = we_cnt;
    h = halt_cnt;
    pw();
    chk(32'(we_cnt - c), 32'h20);
    chk(32'(halt_cnt - h >= 32 + PROG), 32'h1);
    chk(32'(we_page), 32'h2AF);
    for (int s = 0; s < 32; s++) chk(32'(cap[s]), (s % 2) ? 32'hFFFF : 32'hA500 + s);
    pw();
    for (int s = 0; s < 32; s++) chk(32'(cap[s]), 32'hFFFF);
    $display("test page done");
  endtask

  // EEPROM write and re-enable both discard a loaded buffer.
  task automatic t_discard();
    ld(3, 16'h1111, 0);
    ee_busy <= 1'b1;
    wr(32'h0000_0005);
    rd(fsps_pkg::CTRL_OFS, 32'h0);
    rd(fsps_pkg::STAT_OFS, 32'h2);
    ee_busy <= 1'b0;
    rd(fsps_pkg::STAT_OFS, 32'h0);
    pw();
    chk(32'(cap[3]), 32'hFFFF);
    ld(4, 16'h2222, 1);
    wr(32'h0000_0011);
    pw();
    chk(32'(cap[4]), 32'hFFFF);
    ld(5, 16'h3333, 0);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    pw();
    chk(32'(cap[5]), 32'hFFFF);
    $display("test discard done");
  endtask

  // Illegal codes, a late store, window restart and an unmapped address.
  task automatic t_illegal();
    int h, e;
    logic [31:0] bad [4];
    bad = '{32'h07, 32'h02, 32'h1F, 32'h0D};
    for (int i = 0; i < 4; i++) begin
      h = halt_cnt;
      wr(bad[i]);
      fsps_cpu_model_i.store(16'h0000, 16'h0000, 0);
      repeat (3) @(posedge clk_i);
      chk(32'(halt_cnt - h), 32'h0);
      rd(fsps_pkg::CTRL_OFS, 32'h0);
    end
    e = er_cnt;
    wr(32'h0000_0003);
    rd(fsps_pkg::STAT_OFS, 32'h4);
    fsps_cpu_model_i.store(16'h0040, 16'h0000, 3);
    repeat (3) @(posedge clk_i);
    chk(32'(er_cnt - e), 32'h0);
    rd(fsps_pkg::CTRL_OFS, 32'h0);
    wr(32'h0000_0003);
    wr(32'h0000_0003);
    fsps_cpu_model_i.store(16'h0040, 16'h0000, 2);
    wait_idle();
    chk(32'(er_cnt - e), 32'h1);
    rd(8'h08, 32'h0);
    $display("test illegal done");
  endtask

  // Reset, then every scenario in turn.
  initial begin
    rst_i    = 1'b1;
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_sel   = 4'hF;
    wb_wdat  = 32'h0000_0000;
    ee_busy  = 1'b0;
    fuse_lo  = 8'h3C;
    lock_b   = 8'hA5;
    fuse_ext = 8'h0F;
    fuse_hi  = 8'hC3;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_lock();
    t_erase(1'b0);
    t_erase(1'b1);
    t_page();
    t_discard();
    t_illegal();
    end_sim();
  end
endmodule
